// ==== logic/pcsp_device.sv ====
// Configured-device end: power-on reset, byte load and initialization
`timescale 1ns/10ps
module pcsp_device
  import pcsp_pkg::*;
#(
  parameter int CONFIG_BYTES = DEF_CONFIG_BYTES,
  parameter int POR_FAST = POR_FAST_CYC,
  parameter int POR_STD = POR_STD_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  pcsp_link_if.device link,
  input wire logic user_init_clock,
  input wire logic [SEL_W-1:0] scheme_select_pins,
  input wire logic supplies_ok,
  input wire logic use_user_clock,
  output logic user_mode,
  output logic weak_pullup_en
);

  localparam int CNT_W = $clog2(CONFIG_BYTES + 1);
  localparam int SYNC_W = SEL_W + 6;

  if (CONFIG_BYTES < 2 || POR_STD > 65535 || POR_FAST > 65535 ||
      POR_FAST < 1 || POR_STD < 1) begin : g_bad_param
    $error("pcsp_device: unsupported parameter value");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers, system clock domain
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] meta;
  logic [SYNC_W-1:0] sync;
  logic usr_prev;
  logic complete;
  logic init_go;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= '0;
      sync <= '0;
      usr_prev <= 1'b0;
    end else begin
      meta <= {user_init_clock, init_go, complete, link.chain_enable_in_n,
               link.config_request_n, supplies_ok, scheme_select_pins};
      sync <= meta;
      usr_prev <= sync[SEL_W+5];
    end
  end

  logic [SEL_W-1:0] s_pins;
  logic s_supplies;
  logic s_request_n;
  logic s_chain_in_n;
  logic s_complete;
  logic s_init_go;
  logic usr_edge;

  assign s_pins = sync[SEL_W-1:0];
  assign s_supplies = sync[SEL_W];
  assign s_request_n = sync[SEL_W+1];
  assign s_chain_in_n = sync[SEL_W+2];
  assign s_complete = sync[SEL_W+3];
  assign s_init_go = sync[SEL_W+4];
  // Sampling at 200 MHz resolves user clocks up to 40 MHz
  assign usr_edge = sync[SEL_W+5] & ~usr_prev;

  // ----------------------------------------------------------------
  // Sequence control
  // ----------------------------------------------------------------
  pcsp_dev_state_t state, next_state;
  pcsp_scheme_t scheme, next_scheme;
  logic fast, next_fast;
  logic [15:0] timer, next_timer;
  logic load_en, next_load_en;
  logic status_oe, next_status_oe;
  logic done_oe, next_done_oe;
  logic next_user_mode;
  logic next_weak_pullup_en;
  logic flash_sel_n, next_flash_sel_n;
  logic sdo_oe, next_sdo_oe;
  logic [15:0] por_target;
  logic tick;

  always_comb begin
    next_state = state;
    next_scheme = scheme;
    next_fast = fast;
    next_timer = timer;
    por_target = fast ? 16'(POR_FAST - 1) :
                 16'(POR_STD - 1);
    tick = use_user_clock ? usr_edge : 1'b1;
    unique case (state)
      dev_por: begin
        next_scheme = pcsp_scheme_t'(s_pins[SEL_SCHEME_LSB +: 2]);
        next_fast = s_pins[SEL_FAST_BIT];
        if (!s_supplies || !s_request_n) begin
          next_timer = '0;
        end else if (timer >= por_target) begin
          next_state = dev_load;
          next_timer = '0;
        end else begin
          next_timer = timer + 16'h0001;
        end
      end
      dev_load: begin
        if (s_complete) begin
          next_state = dev_wait_usr;
          next_timer = '0;
        end
      end
      dev_wait_usr: begin
        // User clock edges are not counted before this delay
        if (timer < 16'(CD2CU_CYC - 1)) begin
          next_timer = timer + 16'h0001;
        end else if (s_init_go) begin
          next_state = dev_init;
          next_timer = '0;
        end
      end
      dev_init: begin
        if (tick) begin
          if (timer == 16'(INIT_CYCLES - 1)) begin
            next_state = dev_user;
          end
          next_timer = timer + 16'h0001;
        end
      end
      dev_user: begin
      end
    endcase
    if (state != dev_por && (!s_supplies || !s_request_n)) begin
      next_state = dev_por;
      next_timer = '0;
    end
    next_status_oe = next_state == dev_por;
    next_load_en = next_state != dev_por && (load_en || !s_chain_in_n);
    next_done_oe = next_state != dev_user;
    next_user_mode = next_state == dev_user;
    next_weak_pullup_en = next_state != dev_user;
    next_flash_sel_n = !(next_state == dev_load &&
                         scheme == active_parallel_scheme);
    next_sdo_oe = next_state == dev_load && scheme == active_serial_scheme;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= dev_por;
      scheme <= active_serial_scheme;
      fast <= 1'b0;
      timer <= '0;
      load_en <= 1'b0;
      status_oe <= 1'b1;
      done_oe <= 1'b1;
      user_mode <= 1'b0;
      weak_pullup_en <= 1'b1;
      flash_sel_n <= 1'b1;
      sdo_oe <= 1'b0;
    end else begin
      state <= next_state;
      scheme <= next_scheme;
      fast <= next_fast;
      timer <= next_timer;
      load_en <= next_load_en;
      status_oe <= next_status_oe;
      done_oe <= next_done_oe;
      user_mode <= next_user_mode;
      weak_pullup_en <= next_weak_pullup_en;
      flash_sel_n <= next_flash_sel_n;
      sdo_oe <= next_sdo_oe;
    end
  end

  assign link.status_oe = status_oe;
  assign link.init_done_oe = done_oe;
  assign link.flash_select_out_n = flash_sel_n;
  assign link.serial_data_out = 1'b0;
  assign link.serial_data_out_oe = sdo_oe;

  // ----------------------------------------------------------------
  // Link domain, clocked by the configuration clock
  // ----------------------------------------------------------------
  // Held in reset by load_en; scheme is static while released
  logic [CNT_W-1:0] byte_count, next_byte_count;
  logic [2:0] bit_count, next_bit_count;
  logic [BYTE_W-1:0] shift, next_shift;
  logic next_complete;
  logic chain_out_n, next_chain_out_n;
  logic parallel;

  always_comb begin
    parallel = scheme == byte_wide_passive_scheme ||
               scheme == active_parallel_scheme;
    next_byte_count = byte_count;
    next_bit_count = bit_count;
    next_shift = shift;
    if (byte_count != CNT_W'(CONFIG_BYTES)) begin
      if (parallel) begin
        // The whole bus is taken as one byte; bit zero alone feeds the serial path
        next_shift = link.data;
        next_byte_count = byte_count + CNT_W'(1);
      end else begin
        next_shift = {shift[BYTE_W-2:0], link.data[0]};
        next_bit_count = bit_count + 3'h1;
        if (bit_count == 3'h7) begin
          next_byte_count = byte_count + CNT_W'(1);
        end
      end
    end
    next_complete = parallel ?
      next_byte_count >= CNT_W'(CONFIG_BYTES - 1) :
      next_byte_count == CNT_W'(CONFIG_BYTES);
    next_chain_out_n = next_byte_count != CNT_W'(CONFIG_BYTES);
  end

  always_ff @(posedge link.config_clock or negedge load_en) begin
    if (!load_en) begin
      byte_count <= '0;
      bit_count <= '0;
      shift <= '0;
      complete <= 1'b0;
      chain_out_n <= 1'b1;
    end else begin
      byte_count <= next_byte_count;
      bit_count <= next_bit_count;
      shift <= next_shift;
      complete <= next_complete;
      chain_out_n <= next_chain_out_n;
    end
  end

  assign link.load_complete_flag = complete;
  assign link.chain_enable_out_n = chain_out_n;

  // ----------------------------------------------------------------
  // Falling edges after completion
  // ----------------------------------------------------------------
  logic [1:0] falls, next_falls;
  logic next_init_go;

  always_comb begin
    next_falls = falls;
    if (complete && falls != 2'(EXTRA_FALLS)) begin
      next_falls = falls + 2'h1;
    end
    next_init_go = next_falls == 2'(EXTRA_FALLS);
  end

  always_ff @(negedge link.config_clock or negedge load_en) begin
    if (!load_en) begin
      falls <= '0;
      init_go <= 1'b0;
    end else begin
      falls <= next_falls;
      init_go <= next_init_go;
    end
  end

endmodule

// ==== logic/pcsp_pkg.sv ====
// Shared constants and types of the parallel configuration slave port
package pcsp_pkg;

  // ----------------------------------------------------------------
  // Widths and buffering
  // ----------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int DEF_CONFIG_BYTES = 16;

  // ----------------------------------------------------------------
  // Scheme select pin layout
  // ----------------------------------------------------------------
  localparam int SEL_W = 3;
  localparam int SEL_SCHEME_LSB = 0;
  localparam int SEL_FAST_BIT = 2;

  // ----------------------------------------------------------------
  // Timing, system clock 200 MHz
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int POR_FAST_US = 1;
  localparam int POR_STD_US = 10;
  localparam int POR_FAST_CYC = POR_FAST_US * CLK_MHZ;
  localparam int POR_STD_CYC = POR_STD_US * CLK_MHZ;
  localparam int CD2CU_NS = 100;
  localparam int CD2CU_CYC = (CD2CU_NS * CLK_MHZ + 999) / 1000;
  localparam int INIT_CYCLES = 3192;
  localparam int USER_CLK_MAX_MHZ = 40;
  localparam int REQ_PULSE_CYC = 8;
  localparam int LINK_HALF_CYC = 2;
  localparam int EXTRA_FALLS = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    active_serial_scheme = 2'b00,
    passive_serial_scheme = 2'b01,
    byte_wide_passive_scheme = 2'b10,
    active_parallel_scheme = 2'b11
  } pcsp_scheme_t;

  typedef enum logic [2:0] {
    dev_por = 3'b000,
    dev_load = 3'b001,
    dev_wait_usr = 3'b010,
    dev_init = 3'b011,
    dev_user = 3'b100
  } pcsp_dev_state_t;

  typedef enum logic [2:0] {
    host_idle = 3'b000,
    host_request = 3'b001,
    host_wait_status = 3'b010,
    host_send = 3'b011,
    host_extra = 3'b100,
    host_wait_done = 3'b101,
    host_done = 3'b110
  } pcsp_host_state_t;

endpackage

// ==== logic/pcsp_link_if.sv ====
// Pin bundle between the configuration host and the configured device
`timescale 1ns/10ps
interface pcsp_link_if;
  import pcsp_pkg::*;
  logic config_request_n;
  logic status_oe;
  logic config_state_flag_n;
  logic load_complete_flag;
  logic init_done_oe;
  logic init_done;
  logic config_clock;
  logic [BYTE_W-1:0] data;
  logic chain_enable_in_n;
  logic chain_enable_out_n;
  logic flash_select_out_n;
  logic serial_data_out;
  logic serial_data_out_oe;

  // Open-drain lines with pull-ups
  assign config_state_flag_n = ~status_oe;
  assign init_done = ~init_done_oe;

  modport device (
    input config_request_n,
    input config_clock,
    input data,
    input chain_enable_in_n,
    output status_oe,
    output load_complete_flag,
    output init_done_oe,
    output chain_enable_out_n,
    output flash_select_out_n,
    output serial_data_out,
    output serial_data_out_oe
  );

  modport host (
    output config_request_n,
    output config_clock,
    output data,
    output chain_enable_in_n,
    input config_state_flag_n,
    input load_complete_flag,
    input init_done,
    input chain_enable_out_n
  );
endinterface

// ==== logic/pcsp_host.sv ====
// Configuration host end with its byte FIFO
`timescale 1ns/10ps
module pcsp_fifo
  import pcsp_pkg::*;
#(
  parameter int WIDTH = BYTE_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_param
    $error("pcsp_fifo: depth must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr, next_wr_ptr;
  logic [AW:0] rd_ptr, next_rd_ptr;
  logic next_in_ready;
  logic next_out_valid;
  logic push;
  logic pop;

  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_ptr = push ? wr_ptr + (AW+1)'(1) : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + (AW+1)'(1) : rd_ptr;
    next_in_ready = next_wr_ptr != {~next_rd_ptr[AW], next_rd_ptr[AW-1:0]};
    next_out_valid = next_wr_ptr != next_rd_ptr;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      in_ready <= next_in_ready;
      out_valid <= next_out_valid;
    end
  end

  // Storage carries no reset; only the pointers qualify it
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  assign out_data = mem[rd_ptr[AW-1:0]];

endmodule

module pcsp_host
  import pcsp_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  pcsp_link_if.host link,
  input wire logic start,
  input wire logic supplies_stable,
  input wire logic [BYTE_W-1:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  output logic busy,
  output logic device_in_user_mode
);

  // ----------------------------------------------------------------
  // Byte buffer and pin synchronisers
  // ----------------------------------------------------------------
  logic [BYTE_W-1:0] fifo_data;
  logic fifo_valid;
  logic pop;

  pcsp_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .in_data(wr_data),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(pop)
  );

  logic [2:0] meta;
  logic [2:0] sync;
  logic done_prev;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= '0;
      sync <= '0;
      done_prev <= 1'b0;
    end else begin
      meta <= {link.init_done, link.load_complete_flag,
               link.config_state_flag_n};
      sync <= meta;
      done_prev <= sync[2];
    end
  end

  // ----------------------------------------------------------------
  // Load sequence and clock divider
  // ----------------------------------------------------------------
  pcsp_host_state_t state, next_state;
  logic [7:0] timer, next_timer;
  logic [1:0] falls, next_falls;
  logic cclk, next_cclk;
  logic have_byte, next_have_byte;
  logic [BYTE_W-1:0] data, next_data;
  logic request_n, next_request_n;
  logic next_busy;
  logic next_user;
  logic wrap;

  always_comb begin
    next_state = state;
    next_timer = timer;
    next_falls = falls;
    next_cclk = cclk;
    next_have_byte = have_byte;
    next_data = data;
    next_user = device_in_user_mode;
    pop = 1'b0;
    wrap = timer == 8'(LINK_HALF_CYC - 1);
    unique case (state)
      host_idle, host_done: begin
        if (start) begin
          next_state = host_request;
          next_timer = '0;
          next_user = 1'b0;
        end
      end
      host_request: begin
        if (timer != 8'hFF) begin
          next_timer = timer + 8'h01;
        end
        if (timer >= 8'(REQ_PULSE_CYC - 1) && supplies_stable) begin
          next_state = host_wait_status;
          next_timer = '0;
        end
      end
      host_wait_status: begin
        next_have_byte = 1'b0;
        if (sync[0]) begin
          next_state = host_send;
        end
      end
      host_send: begin
        next_timer = wrap ? '0 : timer + 8'h01;
        if (wrap) begin
          if (cclk) begin
            next_cclk = 1'b0;
          end else if (sync[1]) begin
            next_state = host_extra;
            next_falls = '0;
          end else if (have_byte) begin
            next_cclk = 1'b1;
            next_have_byte = 1'b0;
          end else if (fifo_valid) begin
            // Clock stands still while the buffer is empty
            pop = 1'b1;
            next_data = fifo_data;
            next_have_byte = 1'b1;
          end
        end
      end
      host_extra: begin
        next_timer = wrap ? '0 : timer + 8'h01;
        if (wrap) begin
          next_cclk = ~cclk;
          if (cclk) begin
            next_falls = falls + 2'h1;
            if (falls == 2'(EXTRA_FALLS - 1)) begin
              next_state = host_wait_done;
            end
          end
        end
      end
      host_wait_done: begin
        if (sync[2] && !done_prev) begin
          next_state = host_done;
          next_user = 1'b1;
        end
      end
      default: begin
        next_state = host_idle;
      end
    endcase
    if (state != host_request && state != host_idle &&
        state != host_done && state != host_wait_status && !sync[0]) begin
      next_state = host_wait_status;
      next_cclk = 1'b0;
    end
    next_request_n = next_state != host_request;
    next_busy = next_state != host_idle && next_state != host_done;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= host_idle;
      timer <= '0;
      falls <= '0;
      cclk <= 1'b0;
      have_byte <= 1'b0;
      data <= '0;
      request_n <= 1'b1;
      busy <= 1'b0;
      device_in_user_mode <= 1'b0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      falls <= next_falls;
      cclk <= next_cclk;
      have_byte <= next_have_byte;
      data <= next_data;
      request_n <= next_request_n;
      busy <= next_busy;
      device_in_user_mode <= next_user;
    end
  end

  assign link.config_clock = cclk;
  assign link.data = data;
  assign link.config_request_n = request_n;
  // Single device: chain input tied active
  assign link.chain_enable_in_n = 1'b0;

endmodule

// ==== verification/pcsp_checker.sv ====
// Link-level assertions between the host and device ends
`timescale 1ns/10ps
module pcsp_checker
  import pcsp_pkg::*;
#(
  parameter int POR_FAST = POR_FAST_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic config_request_n,
  input wire logic status_oe,
  input wire logic load_complete_flag,
  input wire logic init_done_oe,
  input wire logic config_clock,
  input wire logic chain_enable_out_n,
  input wire logic flash_select_out_n,
  input wire logic serial_data_out_oe
);
  // ----
  // Helper counters
  // ----
  int held;
  int next_held;
  int since_done;
  int next_since_done;

  // Saturating, so a long user-mode stay never wraps
  always_comb begin
    next_held = (status_oe && config_request_n) ? held + 1 : 0;
    next_since_done = load_complete_flag ? since_done + 1 : 0;
    if (held > 65535) next_held = held;
    if (since_done > 65535) next_since_done = since_done;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      held <= 0;
      since_done <= 0;
    end else begin
      held <= next_held;
      since_done <= next_since_done;
    end
  end

  // ----
  // Properties
  // ----
  sequence req_low_s;
    !config_request_n [*8];
  endsequence

  sequence back_to_reset_s;
    ##[0:2] (init_done_oe && !load_complete_flag);
  endsequence

  req_pulse_a: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(config_request_n) |-> req_low_s) else $error("short request");
  req_status_a: assert property (@(posedge clk) disable iff (!arst_n)
    !config_request_n [*5] |-> status_oe) else $error("status not held");
  por_time_a: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(status_oe) |-> held >= POR_FAST) else $error("early release");
  flags_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(status_oe) |-> back_to_reset_s) else $error("flags kept");
  early_flag_a: assert property (@(posedge config_clock)
    disable iff (!arst_n)
    $rose(load_complete_flag) |-> chain_enable_out_n)
    else $error("flag not early");
  chain_order_a: assert property (@(posedge config_clock)
    disable iff (!arst_n)
    $fell(chain_enable_out_n) |-> load_complete_flag)
    else $error("chain before flag");
  pin_reuse_a: assert property (@(posedge clk) disable iff (!arst_n)
    status_oe [*2] |-> !serial_data_out_oe && flash_select_out_n)
    else $error("reuse in reset");
  done_order_a: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(init_done_oe) |-> load_complete_flag && !status_oe)
    else $error("done out of order");
  init_count_a: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(init_done_oe) |-> since_done >= CD2CU_CYC + INIT_CYCLES)
    else $error("init too short");
endmodule

// ==== verification/parallel_config_slave_port_bench.sv ====
// Self-checking bench joining host and device ends over the link
`timescale 1ns/10ps
module parallel_config_slave_port_bench;
  import pcsp_pkg::*;
  // One more than the buffer holds: the flag comes a byte early
  localparam int NB = FIFO_DEPTH + 1;
  localparam int PF = 4;
  localparam int PS = 20;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic user_init_clock = 1'b0;
  logic [SEL_W-1:0] scheme_select_pins = 3'h6;
  logic supplies_ok = 1'b1;
  logic use_user_clock = 1'b0;
  logic start = 1'b0;
  logic supplies_stable = 1'b1;
  logic [BYTE_W-1:0] wr_data = 8'h00;
  logic wr_valid = 1'b0;
  logic wr_ready, busy, device_in_user_mode, user_mode, weak_pullup_en;
  int fails = 0;
  int total_checks = 0;
  int rises = 0;
  bit chk_en = 1'b0;
  logic [BYTE_W-1:0] exp_q[$];
  logic [BYTE_W-1:0] cap_q[$];

  pcsp_link_if link();

  always #2.5 clk = ~clk;
  // User clock at its 40 MHz ceiling, phase unrelated to clk
  initial begin
    #1.3;
    forever #12.5 user_init_clock = ~user_init_clock;
  end

  pcsp_device #(.CONFIG_BYTES(NB), .POR_FAST(PF), .POR_STD(PS))
    pcsp_device_inst (.clk(clk), .arst_n(arst_n), .link(link.device),
    .user_init_clock(user_init_clock),
    .scheme_select_pins(scheme_select_pins), .supplies_ok(supplies_ok),
    .use_user_clock(use_user_clock), .user_mode(user_mode),
    .weak_pullup_en(weak_pullup_en));
  pcsp_host pcsp_host_inst (.clk(clk), .arst_n(arst_n), .link(link.host),
    .start(start), .supplies_stable(supplies_stable), .wr_data(wr_data),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .busy(busy),
    .device_in_user_mode(device_in_user_mode));
  pcsp_checker #(.POR_FAST(PF)) pcsp_checker_inst (.clk(clk),
    .arst_n(arst_n), .config_request_n(link.config_request_n),
    .status_oe(link.status_oe),
    .load_complete_flag(link.load_complete_flag),
    .init_done_oe(link.init_done_oe), .config_clock(link.config_clock),
    .chain_enable_out_n(link.chain_enable_out_n),
    .flash_select_out_n(link.flash_select_out_n),
    .serial_data_out_oe(link.serial_data_out_oe));

  // ----
  // Compare and drive tasks
  // ----
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic chk_span(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi) begin
      fails++;
      $display("Error at %0t: got %0h expected %0h", $time, got, lo);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic reset_dut();
    arst_n = 1'b0;
    tick(2);
    arst_n = 1'b1;
  endtask

  // Bytes seen on the wire, counted on each capture edge
  always @(posedge link.config_clock) begin
    if (chk_en && rises < NB) begin
      cap_q.push_back(link.data);
      rises++;
    end
  end
  always @(negedge link.config_clock) begin
    if (chk_en && rises > 0) begin
      chk(link.load_complete_flag, rises >= NB - 1);
      chk(link.chain_enable_out_n, rises < NB);
      chk_en = (rises < NB);
    end
  end

  task automatic run_cfg(input logic [2:0] sel, input logic uuc,
                         input logic slow);
    int i;
    int k;
    int lo;
    scheme_select_pins = sel;
    use_user_clock = uuc;
    supplies_stable = ~slow;
    exp_q.delete();
    cap_q.delete();
    rises = 0;
    chk_en = sel[1];
    // Fill one past depth; the host is idle, so nothing drains
    for (i = 0; sel[1] && i <= FIFO_DEPTH; i++) begin
      wr_data = BYTE_W'($urandom);
      wr_valid = 1'b1;
      chk(wr_ready, i < FIFO_DEPTH);
      if (i < FIFO_DEPTH) exp_q.push_back(wr_data);
      tick(1);
    end
    wr_valid = 1'b0;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    tick(6);
    chk(user_mode, 1'b0);
    chk(link.load_complete_flag, 1'b0);
    chk(link.config_state_flag_n, 1'b0);
    if (slow) begin
      tick(20);
      chk(link.config_request_n, 1'b0);
      supplies_stable = 1'b1;
    end
    for (k = 0; k < 100 && link.config_request_n !== 1'b1; k++) tick(1);
    for (k = 0; k < 100 && link.config_state_flag_n !== 1'b1; k++) tick(1);
    lo = sel[SEL_FAST_BIT] ? PF : PS;
    chk_span(k, lo, lo + 5);
    tick(1);
    chk(link.flash_select_out_n, sel[1:0] != 2'b11);
    chk(link.serial_data_out_oe, sel[1:0] == 2'b00);
    if (!sel[1]) return;
    for (k = 0; k < 400 && link.load_complete_flag !== 1'b1; k++) tick(1);
    for (k = 0; k < 20000 && user_mode !== 1'b1; k++) tick(1);
    lo = uuc ? INIT_CYCLES * 5 : CD2CU_CYC + INIT_CYCLES;
    chk_span(k, lo, lo + 60);
    chk(link.init_done, 1'b1);
    chk(weak_pullup_en, 1'b0);
    tick(6);
    chk(device_in_user_mode, 1'b1);
    chk(busy, 1'b0);
    chk(wr_ready, 1'b1);
    chk_span(cap_q.size(), NB, NB);
    // Last byte stays on the bus through the extra edges
    for (i = 0; i < NB; i++) begin
      k = (i < NB - 1) ? i : NB - 2;
      chk(cap_q[i], exp_q[k]);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ----
  // Sequence and watchdog
  // ----
  initial begin
    void'($urandom(27130));
    reset_dut();
    run_cfg(3'h4, 1'b0, 1'b0);
    reset_dut();
    $display("Test 1 done");
    run_cfg(3'h5, 1'b0, 1'b0);
    reset_dut();
    $display("Test 2 done");
    run_cfg(3'h6, 1'b0, 1'b0);
    $display("Test 3 done");
    run_cfg(3'h3, 1'b1, 1'b1);
    $display("Test 4 done");
    supplies_ok = 1'b0;
    tick(4);
    chk(link.config_state_flag_n, 1'b0);
    chk(link.load_complete_flag, 1'b0);
    chk(link.init_done, 1'b0);
    chk(user_mode, 1'b0);
    chk(weak_pullup_en, 1'b1);
    supplies_ok = 1'b1;
    tick(2);
    $display("Test 5 done");
    conclude();
  end

  // Two inits (one on the slow user clock) need about 20000 cycles
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    conclude();
  end
endmodule
